// ===== rx_mux_defines.vh
// Register offsets, field positions, reset values and timing counts for the receive output mux
`ifndef RX_MUX_DEFINES_VH
`define RX_MUX_DEFINES_VH

// Register offsets
`define REG_REF_CTRL 8'h02
`define REG_ROUTE_CTRL 8'h03
`define REG_CLAMP 8'h07
`define REG_CLK_CTRL 8'h08
`define REG_STATUS 8'h09

// Field positions
`define BIT_REF_PWRDN 0
`define BIT_ADC10_PWRDN 1
`define BIT_VIDEO_ROUTE 6
`define BIT_VIDEO_EN 7
`define BIT_CLK_DIRECT 0

// Reset values
`define RST_REF_CTRL 8'h00
`define RST_ROUTE_CTRL 8'h00
`define RST_CLAMP 8'h00
`define RST_CLK_CTRL 8'h00

// Converter widths
`define W10 10
`define W12 12

// Master clock cycles per sample in multiplier mode
`define MCLK_PER_SAMPLE 4
`define PHASE_LAST 2'h3

`endif

// ===== straight_binary_coder.v
// Saturating two's-complement to straight-binary converter word coder
`timescale 1ns/100ps
module straight_binary_coder #(
	parameter N = 12
) (
	// Raw converter result, one bit of overrange
	input wire signed [N:0] raw_i,
	// Coded word
	output reg [N-1:0] code_o
);

	localparam signed [N:0] MAX_V = {2'b00, {(N-1){1'b1}}};
	localparam signed [N:0] MIN_V = {2'b11, {(N-1){1'b0}}};

	// Clip, then flip the sign bit; zero becomes midscale
	always @* begin
		if (raw_i > MAX_V) begin
			code_o = {N{1'b1}};
		end else if (raw_i < MIN_V) begin
			code_o = {N{1'b0}};
		end else begin
			code_o = {~raw_i[N-1], raw_i[N-2:0]};
		end
	end

endmodule // straight_binary_coder

// ===== sample_clock_select.v
// Converter sample strobe from the multiplier divider or the oscillator input
`include "rx_mux_defines.vh"
`timescale 1ns/100ps
module sample_clock_select (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Source select and oscillator pin
	input wire direct_i,
	input wire oscillator_input_i,
	// Sample strobe and divider phase
	output wire sample_stb_o,
	output wire [1:0] phase_o
);

	reg [1:0] phase_reg;
	reg osc_meta_reg;
	reg osc_sync_reg;
	reg osc_prev_reg;

	// Divide-by-four phase for the multiplier-derived sample clock
	always @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	// Two flops before the edge detector; the pin is asynchronous
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			osc_meta_reg <= oscillator_input_i;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	// Direct mode samples on each rising pin edge
	assign sample_stb_o = direct_i ? (osc_sync_reg & ~osc_prev_reg) : (phase_reg == `PHASE_LAST);
	assign phase_o = phase_reg;

endmodule // sample_clock_select

// ===== rx_adc_output_mux.v
// Receive converter output multiplexer with its control registers
//
// Contract
// - One 10-bit and two 12-bit converters feed the output mux.
// - Sample clock comes from the oscillator input or from the multiplier.
// - Both 12-bit results share one 12-bit bus at master clock word rate.
// - Straight binary: zero is midscale, overrange clips to all ones or zeros.
// - Both output buses update on every rising master clock edge.
// - Frame sync marks the start of each 10-bit symbol.
// - All results leave the buses once every two master clock cycles.
// - Frame sync is high for every second 10-bit word when powered.
// - A bit in register 0x02 powers down the internal references.
// - The clamp forces black level to the clamp level register value.
// - Video input disabled after reset; bit 7 of 0x07 enables it.
// - Bit 6 of 0x03 routes video: zero first, one second converter.
// - Register 0x08 selects sample clock; direct needs master at twice oscillator.
`include "rx_mux_defines.vh"
`timescale 1ns/100ps
module rx_adc_output_mux (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Oscillator pin, used as sample clock in direct mode
	input wire oscillator_input_i,
	// Raw converter results, two's complement with one overrange bit
	input wire [`W10:0] adc10_raw_i,
	input wire [`W12:0] first_twelve_bit_converter_raw_i,
	input wire [`W12:0] second_twelve_bit_converter_raw_i,
	// Receive data port
	output reg [`W10-1:0] ten_bit_if_output_o,
	output reg [`W12-1:0] twelve_bit_if_output_o,
	output reg rx_frame_sync_o,
	// Converter sample strobe towards the converter cores
	output wire adc_sample_o,
	// Analog controls
	output wire ref_pwrdn_o,
	output wire adc10_pwrdn_o,
	output wire video_enable_o,
	output wire video_to_first_o,
	output wire video_to_second_o,
	output wire [6:0] clamp_level_o,
	output wire clk_direct_o
);

	////////////////////////////////////////////////////////////////////////
	// Control registers

	reg [7:0] ref_ctrl_reg;
	reg [7:0] route_ctrl_reg;
	reg [7:0] video_clamp_level_ctrl_reg;
	reg [7:0] clk_ctrl_reg;
	reg [7:0] rdata_next;

	// One write enable per register; the status offset has none, so it stays read-only
	wire wr_ref;
	wire wr_route;
	wire wr_clamp;
	wire wr_clk;

	assign wr_ref = wr_i & (addr_i == `REG_REF_CTRL);
	assign wr_route = wr_i & (addr_i == `REG_ROUTE_CTRL);
	assign wr_clamp = wr_i & (addr_i == `REG_CLAMP);
	assign wr_clk = wr_i & (addr_i == `REG_CLK_CTRL);

	// Reference and 10-bit converter power-down bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_ctrl_reg <= `RST_REF_CTRL;
		end else if (wr_ref) begin
			ref_ctrl_reg <= wdata_i;
		end
	end

	// Video routing bit
	always @(posedge clk_i) begin
		if (rst_i) begin
			route_ctrl_reg <= `RST_ROUTE_CTRL;
		end else if (wr_route) begin
			route_ctrl_reg <= wdata_i;
		end
	end

	// Video enable and clamp level; reset leaves the video input disconnected
	always @(posedge clk_i) begin
		if (rst_i) begin
			video_clamp_level_ctrl_reg <= `RST_CLAMP;
		end else if (wr_clamp) begin
			video_clamp_level_ctrl_reg <= wdata_i;
		end
	end

	// Sample clock source; a change mid-stream may drop or repeat one sample
	always @(posedge clk_i) begin
		if (rst_i) begin
			clk_ctrl_reg <= `RST_CLK_CTRL;
		end else if (wr_clk) begin
			clk_ctrl_reg <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog control outputs

	// Internal references off when external ones are fitted
	assign ref_pwrdn_o = ref_ctrl_reg[`BIT_REF_PWRDN];

	// The 10-bit converter power-down also silences frame sync
	assign adc10_pwrdn_o = ref_ctrl_reg[`BIT_ADC10_PWRDN];

	// Video stays disconnected from both converters until enabled
	assign video_enable_o = video_clamp_level_ctrl_reg[`BIT_VIDEO_EN];
	assign video_to_first_o = video_enable_o & ~route_ctrl_reg[`BIT_VIDEO_ROUTE];
	assign video_to_second_o = video_enable_o & route_ctrl_reg[`BIT_VIDEO_ROUTE];

	// Clamp target; bit 7 of the same register is the enable
	assign clamp_level_o = video_clamp_level_ctrl_reg[6:0];

	// Clock source choice; the master clock rate itself is set outside
	assign clk_direct_o = clk_ctrl_reg[`BIT_CLK_DIRECT];

	////////////////////////////////////////////////////////////////////////
	// Sample clock

	wire sample_stb;
	wire [1:0] phase;

	sample_clock_select u_clk_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.direct_i(clk_direct_o),
		.oscillator_input_i(oscillator_input_i),
		.sample_stb_o(sample_stb),
		.phase_o(phase)
	);

	assign adc_sample_o = sample_stb;

	////////////////////////////////////////////////////////////////////////
	// Coding

	wire [`W10-1:0] code10;
	wire [`W12-1:0] code12a;
	wire [`W12-1:0] code12b;

	// One coder per converter, each saturating to its own width
	straight_binary_coder #(.N(`W10)) u_code10 (
		.raw_i(adc10_raw_i),
		.code_o(code10)
	);

	// The two 12-bit channels are identical, so one loop builds both coders
	wire [`W12:0] raw12 [0:1];
	wire [`W12-1:0] code12 [0:1];

	assign raw12[0] = first_twelve_bit_converter_raw_i;
	assign raw12[1] = second_twelve_bit_converter_raw_i;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_code12
			straight_binary_coder #(.N(`W12)) u_code12 (
				.raw_i(raw12[ch]),
				.code_o(code12[ch])
			);
		end
	endgenerate

	assign code12a = code12[0];
	assign code12b = code12[1];

	////////////////////////////////////////////////////////////////////////
	// Sample capture

	reg [`W10-1:0] hold10_reg;
	reg [`W12-1:0] hold12a_reg;
	reg [`W12-1:0] hold12b_reg;
	reg [`W10-1:0] pair10_reg;
	reg [`W12-1:0] pair12a_reg;
	reg [`W12-1:0] pair12b_reg;
	reg mux_sel_reg;
	reg fresh_reg;
	reg fresh_next;

	// All three converters are latched on the same strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			hold10_reg <= {`W10{1'b0}};
			hold12a_reg <= {`W12{1'b0}};
			hold12b_reg <= {`W12{1'b0}};
		end else if (sample_stb) begin
			hold10_reg <= code10;
			hold12a_reg <= code12a;
			hold12b_reg <= code12b;
		end
	end

	// Word slot: 0 carries the first converter, 1 the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			mux_sel_reg <= 1'b0;
		end else begin
			mux_sel_reg <= ~mux_sel_reg;
		end
	end

	// A new sample waits for the next pair start, so a pair never mixes samples
	always @* begin
		fresh_next = fresh_reg;
		if (sample_stb) begin
			fresh_next = 1'b1;
		end else if (mux_sel_reg) begin
			fresh_next = 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			fresh_reg <= 1'b0;
		end else begin
			fresh_reg <= fresh_next;
		end
	end

	// A boundary takes the waiting sample; with none waiting the pair already matches
	wire pair_load;

	assign pair_load = mux_sel_reg & fresh_reg;

	// Pair registers reload only at a pair boundary
	always @(posedge clk_i) begin
		if (rst_i) begin
			pair10_reg <= {`W10{1'b0}};
			pair12a_reg <= {`W12{1'b0}};
			pair12b_reg <= {`W12{1'b0}};
		end else if (pair_load) begin
			pair10_reg <= hold10_reg;
			pair12a_reg <= hold12a_reg;
			pair12b_reg <= hold12b_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output port

	reg [`W10-1:0] out10_next;
	reg [`W12-1:0] out12_next;
	reg sync_next;

	// Sync opens slot 0 of each pair and stays low while the 10-bit converter sleeps
	wire slot_first;
	wire ten_running;

	assign slot_first = ~mux_sel_reg;
	assign ten_running = ~adc10_pwrdn_o;

	// Slot 0 carries the first converter and raises sync; slot 1 the second
	always @* begin
		out10_next = pair10_reg;
		if (mux_sel_reg) begin
			out12_next = pair12b_reg;
		end else begin
			out12_next = pair12a_reg;
		end
		sync_next = slot_first & ten_running;
	end

	// The 10-bit word repeats the pair value in both slots; no clock enable on the port
	always @(posedge clk_i) begin
		if (rst_i) begin
			ten_bit_if_output_o <= {`W10{1'b0}};
		end else begin
			ten_bit_if_output_o <= out10_next;
		end
	end

	// Every edge drives the next converter word onto the 12-bit bus
	always @(posedge clk_i) begin
		if (rst_i) begin
			twelve_bit_if_output_o <= {`W12{1'b0}};
		end else begin
			twelve_bit_if_output_o <= out12_next;
		end
	end

	// Sync is registered with the words, so the receiver sees both on one edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_frame_sync_o <= 1'b0;
		end else begin
			rx_frame_sync_o <= sync_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status and read back

	reg [3:0] pair_cnt_reg;

	// Pair counter lets software see the port running
	always @(posedge clk_i) begin
		if (rst_i) begin
			pair_cnt_reg <= 4'h0;
		end else if (mux_sel_reg) begin
			pair_cnt_reg <= pair_cnt_reg + 4'h1;
		end
	end

	// Status word: pair count, sample pending, slot and divider phase
	wire [7:0] status_word;

	assign status_word = {pair_cnt_reg, fresh_reg, mux_sel_reg, phase};

	// Unmapped offsets read zero
	always @* begin
		case (addr_i)
			`REG_REF_CTRL: begin
				rdata_next = ref_ctrl_reg;
			end
			`REG_ROUTE_CTRL: begin
				rdata_next = route_ctrl_reg;
			end
			`REG_CLAMP: begin
				rdata_next = video_clamp_level_ctrl_reg;
			end
			`REG_CLK_CTRL: begin
				rdata_next = clk_ctrl_reg;
			end
			`REG_STATUS: begin
				rdata_next = status_word;
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= rdata_next;
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule // rx_adc_output_mux

// ===== rx_mux_chk.sv
// Port assertions for the receive output mux
`timescale 1ns/100ps
module rx_mux_chk (
	// Clock, reset, register writes
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	// Watched outputs
	input wire logic rx_frame_sync_o,
	input wire logic [9:0] ten_bit_if_output_o,
	input wire logic adc_sample_o,
	input wire logic clk_direct_o,
	input wire logic adc10_pwrdn_o,
	input wire logic ref_pwrdn_o,
	input wire logic video_enable_o,
	input wire logic video_to_second_o,
	input wire logic [6:0] clamp_level_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// Sync opens the first slot, lasts one cycle, stays quiet in power-down
	a_sync_first: assert property ($fell(rst_i) |=> rx_frame_sync_o) else $error("no sync");
	a_sync_pulse: assert property (rx_frame_sync_o |=> !rx_frame_sync_o) else $error("sync long");
	a_sync_quiet: assert property (adc10_pwrdn_o && $past(adc10_pwrdn_o) |-> !rx_frame_sync_o) else $error("sync");
	// Both words of a pair repeat one 10-bit sample
	a_ten_pair: assert property (rx_frame_sync_o |=> $stable(ten_bit_if_output_o)) else $error("ten");
	// Multiplier mode samples every fourth clock; a switch to direct mode ends the pattern
	a_pll_rate: assert property (adc_sample_o && !clk_direct_o |=>
		(!adc_sample_o [*3] ##1 adc_sample_o) or (##[0:3] clk_direct_o)) else $error("rate");
	// Writes reach the analog controls in the next cycle
	a_ref_write: assert property (wr_i && addr_i == 8'h02 |=>
		{adc10_pwrdn_o, ref_pwrdn_o} == 2'($past(wdata_i))) else $error("pd");
	a_video_write: assert property (wr_i && addr_i == 8'h07 |=>
		{video_enable_o, clamp_level_o} == $past(wdata_i)) else $error("video");
	a_route_write: assert property (wr_i && addr_i == 8'h03 |=>
		video_to_second_o == (video_enable_o && ($past(wdata_i) & 8'h40) != 8'h00)) else $error("route");
endmodule // rx_mux_chk

// ===== rx_cap.sv
// Baseband capture model for the receive data port
`timescale 1ns/100ps
module rx_cap (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Receive data port
	input wire logic [11:0] twelve_i,
	input wire logic sync_i,
	// Captured pair
	output logic [11:0] first_o,
	output logic [11:0] second_o,
	output logic pair_o
);
	logic half_reg;
	// Sync marks the first word; the word after it completes the pair
	always @(posedge clk_i) begin
		pair_o <= 1'b0;
		if (rst_i) begin
			half_reg <= 1'b0;
		end else if (sync_i) begin
			first_o <= twelve_i;
			half_reg <= 1'b1;
		end else if (half_reg) begin
			second_o <= twelve_i;
			half_reg <= 1'b0;
			pair_o <= 1'b1;
		end
	end
endmodule // rx_cap

// ===== tb.sv
// Self-checking bench for the receive output mux
`timescale 1ns/100ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic osc = 1'b0;
	logic [10:0] raw_t = 11'h000;
	logic [12:0] raw_a = 13'h0000;
	logic [12:0] raw_b = 13'h0000;
	logic [7:0] rdata;
	logic [9:0] ten;
	logic [11:0] twelve, cap_a, cap_b;
	logic sync, smp, pd_ref, pd10, ven, v_a, v_b, direct, pair;
	logic [6:0] clamp;
	int n_mismatch = 0;
	int n_compared = 0;
	int cnt;
	int k;
	// Inputs span midscale, one step, overrange and underrange
	int ra[4] = '{0, 1, 3000, -2047};
	int rb[4] = '{-1, 2047, -2048, -2049};
	int rt[4] = '{0, -512, 600, -1};
	logic [11:0] ea[4] = '{12'h800, 12'h801, 12'hFFF, 12'h001};
	logic [11:0] eb[4] = '{12'h7FF, 12'hFFF, 12'h000, 12'h000};
	logic [9:0] et[4] = '{10'h200, 10'h000, 10'h3FF, 10'h1FF};
	////////////////////////////////////////
	// Master clock at 10 MHz, oscillator at half that rate with unrelated phase
	always #50 clk_i = ~clk_i;
	initial begin
		#37;
		forever #100 osc = ~osc;
	end
	rx_adc_output_mux i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .oscillator_input_i(osc), .adc10_raw_i(raw_t), .first_twelve_bit_converter_raw_i(raw_a), .second_twelve_bit_converter_raw_i(raw_b),
		.ten_bit_if_output_o(ten), .twelve_bit_if_output_o(twelve), .rx_frame_sync_o(sync), .adc_sample_o(smp),
		.ref_pwrdn_o(pd_ref), .adc10_pwrdn_o(pd10), .video_enable_o(ven), .video_to_first_o(v_a),
		.video_to_second_o(v_b), .clamp_level_o(clamp), .clk_direct_o(direct));
	rx_cap i_cap (.clk_i(clk_i), .rst_i(rst_i), .twelve_i(twelve), .sync_i(sync), .first_o(cap_a),
		.second_o(cap_b), .pair_o(pair));
	////////////////////////////////////////
	// Compare, report and close
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Register port cycles: one-cycle strobes, read data in the next cycle only
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		check("rdata", {4'h0, rdata}, {4'h0, exp});
	endtask
	// Count sample strobes over 40 master clocks
	task automatic count_samples();
		cnt = 0;
		repeat (40) begin
			@(posedge clk_i);
			#1;
			if (smp === 1'b1) cnt++;
		end
	endtask
	// Hold one set of converter results and wait for settled pairs
	task automatic run_case(input int i);
		@(posedge clk_i);
		raw_a <= 13'(ra[i]);
		raw_b <= 13'(rb[i]);
		raw_t <= 11'(rt[i]);
		k = 0;
		for (cnt = 0; cnt < 40 && k < 6; cnt++) begin
			@(posedge clk_i);
			#1;
			if (pair === 1'b1) k++;
		end
		if (k < 6) begin
			n_mismatch++;
			end_of_test();
		end else begin
			check("first", cap_a, ea[i]);
			check("second", cap_b, eb[i]);
			check("ten", {2'b00, ten}, {2'b00, et[i]});
		end
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		reg_read(8'h07, 8'h00);
		reg_read(8'h05, 8'h00);
		check("video", {ven, v_a, v_b}, 3'b000);
		for (int i = 0; i < 4; i++) run_case(i);
		// Enable video on the first converter, then move it to the second
		reg_write(8'h07, 8'hA5);
		check("video", {ven, v_a, v_b, clamp}, {3'b110, 7'h25});
		reg_write(8'h03, 8'h40);
		check("route", {ven, v_a, v_b}, 3'b101);
		reg_read(8'h07, 8'hA5);
		// Power down the 10-bit converter, then only the references
		reg_write(8'h02, 8'h02);
		count_samples();
		check("pd", {pd10, pd_ref, sync}, 3'b100);
		reg_write(8'h02, 8'h01);
		check("ref", {pd10, pd_ref}, 2'b01);
		count_samples();
		check("pll rate", 12'(cnt), 12'd10);
		// Direct sampling: one strobe per oscillator period
		reg_write(8'h08, 8'h01);
		count_samples();
		check("direct", {direct, cnt >= 18 && cnt <= 22}, 2'b11);
		end_of_test();
	end
endmodule // tb
bind rx_adc_output_mux rx_mux_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.rx_frame_sync_o(rx_frame_sync_o), .ten_bit_if_output_o(ten_bit_if_output_o), .adc_sample_o(adc_sample_o),
	.clk_direct_o(clk_direct_o), .adc10_pwrdn_o(adc10_pwrdn_o), .ref_pwrdn_o(ref_pwrdn_o),
	.video_enable_o(video_enable_o), .video_to_second_o(video_to_second_o), .clamp_level_o(clamp_level_o));
